// [vdc_regs.sv]
// control and status register bank of one video decoder channel, with its control logic
// assumes a single AHB-Lite master on sys_clk; decoder-side inputs are on sys_clk,
// hsync_pin and switch_pin come from pins and are filtered here
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module vdc_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [9:0] adc_sample,
    input wire logic adc_valid,
    input wire logic frame_tick,
    input wire logic video_present,
    input wire logic format_change,
    input wire logic sec_video_present,
    input wire logic sec_format_change,
    input wire logic subcarrier_443,
    input wire logic hsync_pin,
    input wire logic sync_missed,
    input wire logic switch_pin,
    input wire logic field_info,
    input wire logic active_info,
    input wire logic [20:0] meas_offset,
    input wire logic [9:0] sync_level,
    input wire logic [9:0] blank_level,
    input wire logic [3:0] digital_gain,
    input wire logic [7:0] std_status,
    input wire logic non_interlace,
    input wire vdc_pkg::vdc_pix_t pix_in,
    output vdc_pkg::vdc_pix_t pix_out,
    output logic [3:0] analog_gain,
    output logic gain_updating,
    output logic switch_select,
    output logic [20:0] offset_value,
    output logic offset_tracking,
    output logic [9:0] blank_level_out,
    output logic line_tick,
    output logic line_decode_active,
    output logic linelock_check_enable,
    output logic chroma_resampler_54m,
    output logic [9:0] hue_value,
    output logic [9:0] active_lines,
    output logic status_pin,
    output logic irq
);

    typedef struct packed {
        logic [vdc_pkg::NREG-1:0][7:0] rw;
        logic [31:0] rdata;
        logic dph_wr;
        logic [6:0] dph_idx;
        logic [7:0] flags;
        logic [3:0] gain;
        logic over;
        logic gupd;
        logic [7:0] swcnt;
        logic swsel;
        logic [2:0] sw_sh;
        logic [2:0] hs_sh;
        logic swf;
        logic hsf;
        logic vp_d;
        logic svp_d;
        logic [4:0] fcnt;
        logic [2:0] rot;
        logic tracking;
        logic entered;
        logic [20:0] held;
        logic [20:0] offs;
        logic lact;
        logic ltick;
        logic llchk;
        logic rate;
        vdc_pkg::vdc_pix_t pix;
        logic [9:0] blank;
        logic [9:0] hue;
        logic [9:0] lines;
        logic spin;
        logic irq;
    } vdc_state_t;

    vdc_state_t st_reg;
    vdc_state_t st_next;

    always_comb begin
        logic [7:0] r_main, r_gain, r_thhi, r_misc, r_win, r_cfga, r_cfgb, r_pnl;
        logic [6:0] a_idx;
        logic [7:0] clr, set, rd8, period;
        logic [9:0] thresh;
        logic [20:0] mag, lim, forced;
        logic outside, hs_rise, hs_fall, dual, panel, ntsc;
        logic [4:0] need;
        logic [2:0] code;
        logic [15:0] prod;
        logic [9:0] diff;
        logic [11:0] ped;
        logic [10:0] bsum;
        st_next = st_reg;
        rd8 = 8'h00;
        r_main = st_reg.rw[vdc_pkg::R_MAIN];
        r_gain = st_reg.rw[vdc_pkg::R_GAIN_CTL];
        r_thhi = st_reg.rw[vdc_pkg::R_GAIN_TH_HI_SW];
        r_misc = st_reg.rw[vdc_pkg::R_DET_MISC];
        r_win = st_reg.rw[vdc_pkg::R_LIMIT_WIN];
        r_cfga = st_reg.rw[vdc_pkg::R_CFG_A];
        r_cfgb = st_reg.rw[vdc_pkg::R_CFG_B];
        r_pnl = st_reg.rw[vdc_pkg::R_PANEL_PIN];
        a_idx = haddr[8:2];
        dual = r_main[vdc_pkg::B_DUAL_EN];

        // bus data phase: store writes; flag clears come from the same phase
        clr = 8'h00;
        if (st_reg.dph_wr) begin
            if (vdc_pkg::is_rw(st_reg.dph_idx)) begin
                st_next.rw[st_reg.dph_idx] = hwdata[7:0];
            end
            if (st_reg.dph_idx == vdc_pkg::R_INT_FLAGS) begin
                clr = hwdata[7:0] & vdc_pkg::FLAG_MASK;
            end
        end

        // pin filters: a change counts once the second and third stages agree
        st_next.sw_sh = {st_reg.sw_sh[1:0], switch_pin};
        st_next.hs_sh = {st_reg.hs_sh[1:0], hsync_pin};
        if (st_reg.sw_sh[1] == st_reg.sw_sh[2]) begin
            st_next.swf = st_reg.sw_sh[2];
        end
        if (st_reg.hs_sh[1] == st_reg.hs_sh[2]) begin
            st_next.hsf = st_reg.hs_sh[2];
        end
        hs_rise = st_next.hsf & ~st_reg.hsf;
        hs_fall = ~st_next.hsf & st_reg.hsf;

        // status flags; a set in the clearing cycle survives
        st_next.vp_d = video_present;
        st_next.svp_d = sec_video_present;
        set = 8'h00;
        set[vdc_pkg::F_DET0] = video_present & ~st_reg.vp_d;
        set[vdc_pkg::F_LOST0] = ~video_present & st_reg.vp_d;
        set[vdc_pkg::F_CHG0] = format_change;
        set[vdc_pkg::F_DET1] = dual & sec_video_present & ~st_reg.svp_d;
        set[vdc_pkg::F_LOST1] = dual & ~sec_video_present & st_reg.svp_d;
        set[vdc_pkg::F_CHG1] = dual & sec_format_change;
        st_next.flags = (st_reg.flags & ~clr) | set;
        st_next.irq = |(st_reg.flags & st_reg.rw[vdc_pkg::R_INT_ENABLE] & vdc_pkg::FLAG_MASK);

        // frames decoded since video appeared, saturating at 16
        if (!video_present) begin
            st_next.fcnt = 5'h00;
        end else if (frame_tick && st_reg.fcnt != vdc_pkg::FRAMES_16) begin
            st_next.fcnt = st_reg.fcnt + 5'h01;
        end

        // analog gain: overload seen within a frame steps the gain down at frame end
        st_next.gupd = ~(r_cfga[vdc_pkg::B_FREEZE] && st_reg.fcnt >= vdc_pkg::FREEZE_FRAMES);
        thresh = {r_thhi[1:0], st_reg.rw[vdc_pkg::R_GAIN_TH_LO]};
        if (!r_gain[vdc_pkg::B_AUTO_GAIN]) begin
            st_next.gain = r_gain[7:4];
            st_next.over = 1'b0;
        end else if (st_reg.gupd) begin
            if (frame_tick) begin
                st_next.over = 1'b0;
                if (st_reg.over && st_reg.gain != 4'h0) begin
                    st_next.gain = st_reg.gain - 4'h1;
                end
            end else if (adc_valid && adc_sample > thresh) begin
                st_next.over = 1'b1;
            end
        end

        // dual input switching
        // widened before the add so a setting of 15 gives 128 frames instead of wrapping to 0
        period = ({4'h0, r_thhi[7:4]} + 8'h01) * {3'h0, vdc_pkg::SWITCH_UNIT_FRAMES};
        if (!dual) begin
            st_next.swsel = 1'b0;
            st_next.swcnt = 8'h00;
        end else if (r_thhi[vdc_pkg::B_PIN_SRC]) begin
            st_next.swsel = st_reg.swf;
            st_next.swcnt = 8'h00;
        end else if (frame_tick) begin
            if (st_reg.swcnt >= period - 8'h01) begin
                st_next.swcnt = 8'h00;
                st_next.swsel = ~st_reg.swsel;
            end else begin
                st_next.swcnt = st_reg.swcnt + 8'h01;
            end
        end

        // clock offset tracking and lock window
        mag = meas_offset[20] ? 21'(-meas_offset) : meas_offset;
        lim = 21'(r_win[7:4] * vdc_pkg::PPM_PER_STEP);
        outside = (r_win[7:4] == 4'h0) || (mag > lim);
        if (!video_present) begin
            st_next.entered = 1'b0;
        end else if (!outside) begin
            st_next.entered = 1'b1;
        end
        st_next.tracking = r_cfga[vdc_pkg::B_OFFS_TRK] & ~r_cfga[vdc_pkg::B_OFFS_DIS]
            & (r_cfgb[vdc_pkg::B_POLICY] ? (~st_reg.entered & outside) : outside);
        if (st_reg.tracking) begin
            st_next.held = meas_offset;
        end
        forced = {st_reg.rw[vdc_pkg::R_OFFS_UP][4:0], st_reg.rw[vdc_pkg::R_OFFS_B1],
                  st_reg.rw[vdc_pkg::R_OFFS_B0]};
        st_next.offs = st_reg.rw[vdc_pkg::R_OFFS_CTL][vdc_pkg::B_FORCED] ? forced : st_reg.held;

        // line timing
        st_next.ltick = r_cfgb[vdc_pkg::B_EDGE] ? hs_rise : hs_fall;
        if (!video_present) begin
            st_next.lact = 1'b0;
        end else if (st_reg.ltick) begin
            st_next.lact = 1'b1;
        end else if (sync_missed && !r_cfgb[vdc_pkg::B_FLYWHEEL]) begin
            st_next.lact = 1'b0;
        end

        // line-lock check start
        case (r_cfgb[5:4])
            2'h0: need = 5'h00;
            2'h1: need = vdc_pkg::FRAMES_8;
            default: need = vdc_pkg::FRAMES_16;
        endcase
        st_next.llchk = st_reg.rw[vdc_pkg::R_LINELOCK][vdc_pkg::B_LL_DET] && video_present
            && st_reg.fcnt >= need;
        st_next.rate = r_cfga[vdc_pkg::B_SW_RATE] | (r_cfga[vdc_pkg::B_HW_RATE] & subcarrier_443);

        // no-signal panel colour; rotation steps once per frame
        if (r_pnl[6:4] != vdc_pkg::C_ROTATE) begin
            st_next.rot = 3'h0;
        end else if (frame_tick) begin
            st_next.rot = (st_reg.rot == vdc_pkg::C_BLACK) ? 3'h0 : st_reg.rot + 3'h1;
        end
        if (!r_misc[vdc_pkg::B_COLOURED]) begin
            code = vdc_pkg::C_BLACK;
        end else if (r_pnl[6:4] == vdc_pkg::C_ROTATE) begin
            code = st_reg.rot;
        end else if (r_pnl[6:4] > vdc_pkg::C_BLACK - 3'h1) begin
            code = vdc_pkg::C_BLACK;
        end else begin
            code = r_pnl[6:4];
        end
        panel = ~video_present & r_misc[vdc_pkg::B_PANEL_EN];

        // pixel path
        prod = pix_in.y * st_reg.rw[vdc_pkg::R_CONTRAST];
        if (panel) begin
            st_next.pix = vdc_pkg::PANEL_LUT[code];
        end else begin
            st_next.pix.y = prod[15] ? 8'hff : prod[14:7];
            st_next.pix.cb = r_misc[vdc_pkg::B_MONO] ? vdc_pkg::CHROMA_MID : pix_in.cb;
            st_next.pix.cr = r_misc[vdc_pkg::B_MONO] ? vdc_pkg::CHROMA_MID : pix_in.cr;
        end

        // blank level with optional pedestal
        diff = (blank_level > sync_level) ? blank_level - sync_level : 10'h000;
        ped = 12'(diff * vdc_pkg::PED_MUL) >> vdc_pkg::PED_SHIFT;
        bsum = {1'b0, blank_level} + (r_misc[vdc_pkg::B_PEDESTAL] ? ped[10:0] : 11'h000);
        st_next.blank = bsum[10] ? vdc_pkg::LEVEL_MAX : bsum[9:0];

        st_next.hue = {st_reg.rw[vdc_pkg::R_HUE_HI][1:0], st_reg.rw[vdc_pkg::R_HUE_LO]};
        ntsc = std_status[vdc_pkg::B_NTSC_M] | std_status[vdc_pkg::B_NTSC_443];
        if (!ntsc) begin
            st_next.lines = vdc_pkg::LINES_PAL;
        end else begin
            st_next.lines = st_reg.rw[vdc_pkg::R_COLOUR_RNG][vdc_pkg::B_EXT_LINES]
                ? vdc_pkg::LINES_NTSC_EXT : vdc_pkg::LINES_NTSC;
        end

        // status pin
        if (!st_reg.rw[vdc_pkg::R_PIN_OUT][vdc_pkg::B_GPO]) begin
            st_next.spin = 1'b0;
        end else begin
            unique case (r_pnl[1:0])
                vdc_pkg::PIN_FIELD: st_next.spin = field_info;
                vdc_pkg::PIN_ACTIVE: st_next.spin = active_info;
                vdc_pkg::PIN_NO_VIDEO_INDICATOR: st_next.spin = ~video_present;
                vdc_pkg::PIN_SWITCH: st_next.spin = st_reg.swsel;
            endcase
        end

        // bus address phase; read data is taken from the updated copy so a write just
        // before a read to the same register is seen, except at the offset bytes 0x23 to 0x25, which read back the offset in use
        st_next.dph_wr = 1'b0;
        if (hsel && hready && htrans == vdc_pkg::HTRANS_NONSEQ) begin
            st_next.dph_wr = hwrite;
            st_next.dph_idx = a_idx;
            case (a_idx)
                vdc_pkg::R_STD_STATUS: rd8 = std_status;
                vdc_pkg::R_LOCK_STATUS: rd8 = {~st_reg.tracking, 6'h00, non_interlace};
                vdc_pkg::R_GAIN_RB: rd8 = {digital_gain, st_reg.gain};
                vdc_pkg::R_SYNC_LO: rd8 = sync_level[7:0];
                vdc_pkg::R_BLANK_LO: rd8 = blank_level[7:0];
                vdc_pkg::R_OFFS_B0: rd8 = st_reg.offs[7:0];
                vdc_pkg::R_OFFS_B1: rd8 = st_reg.offs[15:8];
                vdc_pkg::R_OFFS_UP: rd8 = {3'h0, st_reg.offs[20:16]};
                vdc_pkg::R_LEVEL_HI: rd8 = {4'h0, blank_level[9:8], sync_level[9:8]};
                vdc_pkg::R_INT_FLAGS: rd8 = st_next.flags;
                default: rd8 = vdc_pkg::is_rw(a_idx) ? st_next.rw[a_idx] : 8'h00;
            endcase
            st_next.rdata = {24'h000000, rd8};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            for (int i = 0; i < vdc_pkg::NREG; i++) begin
                st_reg.rw[i] <= vdc_pkg::rst_val(7'(i));
            end
            st_reg.gupd <= 1'b1;
            st_reg.lines <= vdc_pkg::LINES_PAL;
            st_reg.hue <= 10'h000;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = st_reg.rdata;
    assign pix_out = st_reg.pix;
    assign analog_gain = st_reg.gain;
    assign gain_updating = st_reg.gupd;
    assign switch_select = st_reg.swsel;
    assign offset_value = st_reg.offs;
    assign offset_tracking = st_reg.tracking;
    assign blank_level_out = st_reg.blank;
    assign line_tick = st_reg.ltick;
    assign line_decode_active = st_reg.lact;
    assign linelock_check_enable = st_reg.llchk;
    assign chroma_resampler_54m = st_reg.rate;
    assign hue_value = st_reg.hue;
    assign active_lines = st_reg.lines;
    assign status_pin = st_reg.spin;
    assign irq = st_reg.irq;

endmodule

`default_nettype wire

// [vdc_pkg.sv]
// constants, register map and carrier types for the video decoder control register bank
// assumes word-aligned AHB-Lite access: byte address is four times the register index
package vdc_pkg;

    localparam int unsigned IDX_W = 7;
    localparam int unsigned NREG = 128;

    // register indexes; byte address = index * 4
    localparam logic [6:0] R_MAIN = 7'h00;
    localparam logic [6:0] R_GAIN_CTL = 7'h02;
    localparam logic [6:0] R_GAIN_TH_LO = 7'h03;
    localparam logic [6:0] R_GAIN_TH_HI_SW = 7'h04;
    localparam logic [6:0] R_HSYNC_TH = 7'h05;
    localparam logic [6:0] R_DET_MISC = 7'h06;
    localparam logic [6:0] R_BURST_TH = 7'h08;
    localparam logic [6:0] R_COMB_CFG = 7'h09;
    localparam logic [6:0] R_PAL_SW = 7'h0c;
    localparam logic [6:0] R_STD_STATUS = 7'h10;
    localparam logic [6:0] R_LOCK_STATUS = 7'h11;
    localparam logic [6:0] R_LIMIT_WIN = 7'h12;
    localparam logic [6:0] R_CFG_A = 7'h13;
    localparam logic [6:0] R_CFG_B = 7'h14;
    localparam logic [6:0] R_OFFS_CTL = 7'h15;
    localparam logic [6:0] R_BLANK_TRK = 7'h17;
    localparam logic [6:0] R_LEVEL_TRK = 7'h18;
    localparam logic [6:0] R_GAIN_RB = 7'h20;
    localparam logic [6:0] R_SYNC_LO = 7'h21;
    localparam logic [6:0] R_BLANK_LO = 7'h22;
    localparam logic [6:0] R_OFFS_B0 = 7'h23;
    localparam logic [6:0] R_OFFS_B1 = 7'h24;
    localparam logic [6:0] R_OFFS_UP = 7'h25;
    localparam logic [6:0] R_LEVEL_HI = 7'h26;
    localparam logic [6:0] R_PANEL_STD = 7'h29;
    localparam logic [6:0] R_PANEL_PIN = 7'h2a;
    localparam logic [6:0] R_COLOUR_RNG = 7'h2b;
    localparam logic [6:0] R_HUE_LO = 7'h2c;
    localparam logic [6:0] R_SATURATION = 7'h2d;
    localparam logic [6:0] R_CONTRAST = 7'h2e;
    localparam logic [6:0] R_BRIGHTNESS = 7'h2f;
    localparam logic [6:0] R_INT_ENABLE = 7'h30;
    localparam logic [6:0] R_INT_FLAGS = 7'h31;
    localparam logic [6:0] R_HUE_HI = 7'h33;
    localparam logic [6:0] R_LINELOCK = 7'h3b;
    localparam logic [6:0] R_PIN_OUT = 7'h7a;

    // field positions
    localparam int unsigned B_DUAL_EN = 5;
    localparam int unsigned B_AUTO_GAIN = 1;
    localparam int unsigned B_PIN_SRC = 2;
    localparam int unsigned B_MONO = 7;
    localparam int unsigned B_PANEL_EN = 3;
    localparam int unsigned B_PEDESTAL = 2;
    localparam int unsigned B_COLOURED = 0;
    localparam int unsigned B_SW_RATE = 7;
    localparam int unsigned B_HW_RATE = 6;
    localparam int unsigned B_FREEZE = 5;
    localparam int unsigned B_OFFS_DIS = 4;
    localparam int unsigned B_OFFS_TRK = 0;
    localparam int unsigned B_EDGE = 3;
    localparam int unsigned B_FLYWHEEL = 2;
    localparam int unsigned B_POLICY = 1;
    localparam int unsigned B_FORCED = 0;
    localparam int unsigned B_EXT_LINES = 1;
    localparam int unsigned B_LL_DET = 5;
    localparam int unsigned B_GPO = 7;
    localparam int unsigned B_NTSC_M = 2;
    localparam int unsigned B_NTSC_443 = 3;

    // flag bit positions
    localparam int unsigned F_DET0 = 0;
    localparam int unsigned F_LOST0 = 1;
    localparam int unsigned F_CHG0 = 2;
    localparam int unsigned F_DET1 = 4;
    localparam int unsigned F_LOST1 = 5;
    localparam int unsigned F_CHG1 = 6;
    localparam logic [7:0] FLAG_MASK = 8'h77;

    // counts and levels
    localparam logic [7:0] CHROMA_MID = 8'h80;
    localparam logic [4:0] FRAMES_8 = 5'h08;
    localparam logic [4:0] FRAMES_16 = 5'h10;
    localparam logic [4:0] SWITCH_UNIT_FRAMES = 5'h08;
    localparam logic [4:0] FREEZE_FRAMES = 5'h10;
    localparam logic [3:0] PPM_PER_STEP = 4'h8;
    localparam logic [9:0] LINES_NTSC = 10'h1e0;
    localparam logic [9:0] LINES_NTSC_EXT = 10'h1e7;
    localparam logic [9:0] LINES_PAL = 10'h240;
    localparam logic [9:0] LEVEL_MAX = 10'h3ff;
    // pedestal of 7.5 ire against a 40 ire sync depth: 7.5 / 40 = 3 / 16
    localparam real PEDESTAL_IRE = 7.5;
    localparam logic [1:0] PED_MUL = 2'h3;
    localparam int unsigned PED_SHIFT = 4;

    localparam logic [2:0] C_BLACK = 3'h5;
    localparam logic [2:0] C_ROTATE = 3'h7;
    localparam logic [1:0] PIN_FIELD = 2'h0;
    localparam logic [1:0] PIN_ACTIVE = 2'h1;
    localparam logic [1:0] PIN_NO_VIDEO_INDICATOR = 2'h2;
    localparam logic [1:0] PIN_SWITCH = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } vdc_pix_t;

    // panel colours: blue, red, white, green, magenta, black
    localparam vdc_pix_t [0:5] PANEL_LUT = '{
        '{8'h29, 8'hf0, 8'h6e}, '{8'h51, 8'h5a, 8'hf0}, '{8'heb, 8'h80, 8'h80},
        '{8'h91, 8'h36, 8'h22}, '{8'h6a, 8'hca, 8'hde}, '{8'h10, 8'h80, 8'h80}};

    function automatic logic is_rw(input logic [6:0] idx);
        case (idx)
            R_MAIN, R_GAIN_CTL, R_GAIN_TH_LO, R_GAIN_TH_HI_SW, R_HSYNC_TH, R_DET_MISC, R_BURST_TH,
            R_COMB_CFG, R_PAL_SW, R_LIMIT_WIN, R_CFG_A, R_CFG_B, R_OFFS_CTL, R_BLANK_TRK,
            R_LEVEL_TRK, R_OFFS_B0, R_OFFS_B1, R_OFFS_UP, R_PANEL_STD, R_PANEL_PIN, R_COLOUR_RNG,
            R_HUE_LO, R_SATURATION, R_CONTRAST, R_BRIGHTNESS, R_INT_ENABLE, R_HUE_HI, R_LINELOCK,
            R_PIN_OUT: is_rw = 1'b1;
            default: is_rw = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input logic [6:0] idx);
        case (idx)
            R_MAIN: rst_val = 8'h0a;
            R_GAIN_CTL: rst_val = 8'h03;
            R_GAIN_TH_LO: rst_val = 8'h63;
            R_GAIN_TH_HI_SW: rst_val = 8'h13;
            R_HSYNC_TH: rst_val = 8'h30;
            R_DET_MISC: rst_val = 8'h0b;
            R_BURST_TH: rst_val = 8'h20;
            R_LIMIT_WIN: rst_val = 8'h3f;
            R_CFG_A: rst_val = 8'h69;
            R_CFG_B: rst_val = 8'h05;
            R_OFFS_CTL: rst_val = 8'h0c;
            R_BLANK_TRK: rst_val = 8'h0a;
            R_PANEL_PIN: rst_val = 8'h02;
            R_COLOUR_RNG: rst_val = 8'h11;
            R_SATURATION: rst_val = 8'h10;
            R_CONTRAST: rst_val = 8'h80;
            default: rst_val = 8'h00;
        endcase
    endfunction

endpackage

// [vdc_regs_asserts.sv]
// port checker for the video decoder control register bank
// assumes registers 0x12 to 0x14 stay at their reset values during the run
`timescale 1ns/1ns
`default_nettype none
module vdc_asserts (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hresp,
    input wire logic hreadyout,
    input wire logic frame_tick,
    input wire logic hsync_pin,
    input wire logic subcarrier_443,
    input wire logic [20:0] meas_offset,
    input wire logic [3:0] analog_gain,
    input wire logic gain_updating,
    input wire logic line_tick,
    input wire logic chroma_resampler_54m,
    input wire logic offset_tracking,
    input wire logic [9:0] active_lines,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    resp_okay_a: assert property (!hresp) else $error("bus response not okay");
    no_wait_a: assert property ($past(nrst) |-> hreadyout) else $error("wait state inserted");
    gain_down_a: assert property (analog_gain < $past(analog_gain) |-> $past(frame_tick)) else $error("gain cut");
    gain_hold_a: assert property (!$past(gain_updating) |-> $stable(analog_gain)) else $error("frozen gain moved");
    line_count_a: assert property (active_lines inside {10'h1e0, 10'h1e7, 10'h240}) else $error("bad lines");
    quiet_sync_a: assert property ($stable(hsync_pin) [*6] |-> !line_tick) else $error("tick without edge");
    fast_rate_a: assert property (subcarrier_443 [*3] |-> chroma_resampler_54m) else $error("rate not raised");
    offset_lock_a: assert property ((meas_offset == 21'h0) [*4] |-> !offset_tracking) else $error("tracking");
    cover property ($rose(irq));
    cover property ($fell(gain_updating));
    cover property (line_tick);
endmodule
bind vdc_regs vdc_asserts i_vdc_asserts (.*);
`default_nettype wire

// [testbench.sv]
// self-checking testbench for the video decoder control register bank
// assumes one AHB-Lite master; decoder-side inputs are driven from this bench
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {logic wr; logic [6:0] a; logic [7:0] d; logic [7:0] e;} vdc_row_t;
    logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, adc_valid = 1'b0, frame_tick = 1'b0;
    logic video_present = 1'b0, format_change = 1'b0, sec_format_change = 1'b0, hreadyout, hresp, hready, irq;
    logic sec_video_present, subcarrier_443, sync_missed, switch_pin, field_info, active_info, non_interlace;
    logic hsync_pin, gain_updating, switch_select, offset_tracking, line_decode_active, linelock_check_enable;
    logic chroma_resampler_54m, status_pin, line_tick;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] digital_gain, analog_gain;
    logic [7:0] m = 8'h00, cnt = 8'h00, q, std_status;
    logic [9:0] adc_sample = 10'h000, sync_level, blank_level, blank_level_out, hue_value, active_lines;
    logic [20:0] meas_offset, offset_value;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int failures = 0, checked = 0;
    vdc_pkg::vdc_pix_t pix_in = 24'h601020, pix_out;
    vdc_row_t rows [10] = '{'{1'b0, 7'h2e, 8'h00, 8'h80}, '{1'b0, 7'h03, 8'h00, 8'h63}, '{1'b0, 7'h13, 8'h00, 8'h69},
        '{1'b0, 7'h2a, 8'h00, 8'h02}, '{1'b1, 7'h30, 8'h04, 8'h04}, '{1'b1, 7'h10, 8'hff, 8'h04},
        '{1'b1, 7'h7f, 8'hff, 8'h00}, '{1'b1, 7'h2d, 8'h3c, 8'h3c}, '{1'b1, 7'h33, 8'h03, 8'h03},
        '{1'b1, 7'h2c, 8'hff, 8'hff}};
    // slow-moving decoder inputs all follow m, so one step exercises them together
    assign {sec_video_present, subcarrier_443, sync_missed, switch_pin, field_info, active_info, non_interlace} = m[6:0];
    // blank sits at twice the sync level so the pedestal has a non-zero sync depth to scale
    assign {meas_offset, sync_level, blank_level, digital_gain} = {13'h0, m, 2'h0, m, 1'b0, m, 1'b0, m[3:0]};
    assign std_status = {m[7:4], 4'h4};
    assign hsync_pin = cnt[3];
    assign hready = hreadyout;
    vdc_regs i_vdc_regs (.*);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cnt <= cnt + 8'h01;
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 23'h0, a, 2'h0};
        do @(posedge sys_clk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'h0, 24'h0, d};
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #3000000;
        failures++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        foreach (rows[i]) begin
            if (rows[i].wr) xfer(1'b1, rows[i].a, rows[i].d);
            xfer(1'b0, rows[i].a, 8'h00);
            chk("register", 32'(q), 32'(rows[i].e));
        end
        chk("hue", 32'(hue_value), 32'h3ff);
        format_change <= 1'b1;
        @(posedge sys_clk) {format_change, sec_format_change} <= 2'b01;
        @(posedge sys_clk) sec_format_change <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("irq", 32'(irq), 32'h1);
        xfer(1'b0, 7'h31, 8'h00);
        chk("flags", 32'(q), 32'h4);
        xfer(1'b1, 7'h31, 8'h04);
        video_present <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("masked irq", 32'(irq), 32'h0);
        xfer(1'b1, 7'h02, 8'hf0);
        xfer(1'b1, 7'h02, 8'hf2);
        chk("gain", 32'(analog_gain), 32'hf);
        {adc_sample, adc_valid} <= {10'h3ff, 1'b1};
        // overload again from frame 13 on: two more steps down, then the freeze holds the gain
        for (int i = 0; i < 18; i++) begin
            @(posedge sys_clk) {frame_tick, adc_valid} <= {1'b1, i >= 13};
            @(posedge sys_clk) frame_tick <= 1'b0;
            @(posedge sys_clk) chk("gain", 32'(analog_gain), 32'(14 - (i >= 14) - (i >= 15)));
        end
        chk("freeze", 32'(gain_updating), 32'h0);
        xfer(1'b1, 7'h06, 8'h8b);
        repeat (2) @(posedge sys_clk);
        chk("mono", 32'(pix_out), {8'h0, pix_in.y, 16'h8080});
        video_present <= 1'b0;
        xfer(1'b1, 7'h06, 8'h09);
        xfer(1'b1, 7'h2a, 8'h12);
        xfer(1'b1, 7'h2b, 8'h13);
        repeat (2) @(posedge sys_clk);
        chk("panel", 32'(pix_out), 32'(vdc_pkg::PANEL_LUT[1]));
        chk("lines", 32'(active_lines), 32'h1e7);
        m <= 8'hff;
        repeat (5) @(posedge sys_clk);
        chk("rate", 32'(chroma_resampler_54m), 32'h1);
        chk("tracking", 32'(offset_tracking), 32'h1);
        xfer(1'b1, 7'h06, 8'h0d);
        xfer(1'b1, 7'h7a, 8'h80);
        xfer(1'b1, 7'h00, 8'h2a);
        xfer(1'b1, 7'h04, 8'h17);
        xfer(1'b1, 7'h23, 8'h3c);
        xfer(1'b1, 7'h24, 8'ha5);
        xfer(1'b1, 7'h25, 8'hf5);
        xfer(1'b1, 7'h15, 8'h0d);
        repeat (5) @(posedge sys_clk);
        chk("pedestal", 32'(blank_level_out), 32'h22d);
        chk("status pin", 32'(status_pin), 32'h1);
        chk("switch", 32'(switch_select), 32'h1);
        chk("forced", 32'(offset_value), 32'h15a53c);
        // mid-run reset, held long enough that no $past check straddles it
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        xfer(1'b0, 7'h06, 8'h00);
        chk("reset", 32'(q), 32'h0b);
        stop_test;
    end
endmodule
`default_nettype wire
